// *** pkg/pomp_pkg.sv ***
// Constants and types for the protected output mode block
package pomp_pkg;
  // Register map: one 16-byte window per timer unit
  localparam logic [2:0] MAP_HI_ZERO = 3'h0;
  localparam int UNIT_SEL_BIT = 4;
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] UNLOCK_OFF = 4'h4;
  localparam logic [3:0] CTRL_OFF = 4'h8;
  localparam int UNITS = 2;

  // Mode register fields
  localparam int ACT_LVL_BIT = 7;
  localparam int FIRST_PB_BIT = 6;
  localparam int MID_PB_BIT = 5;
  localparam int LAST_PB_BIT = 4;
  localparam int STOP_DIS_BIT = 3;
  localparam int SEL_HI_BIT = 1;
  localparam int SEL_LO_BIT = 0;
  localparam logic [7:0] MODE_WMASK = 8'hfb;
  localparam logic [7:0] MODE_RST = 8'h00;

  // Control register fields
  localparam int STAT_BIT = 0;
  localparam int RESTART_BIT = 1;
  localparam int CEN_BIT = 2;
  localparam logic CEN_RST = 1'b0;
  localparam logic STOP_RST = 1'b1;

  // Output levels after reset: first outputs high, partners low
  localparam logic [5:0] OUT_RST = 6'h15;

  // Forced-stop detection modes
  typedef enum logic [1:0] {
    DET_RISE = 2'h0,
    DET_FALL = 2'h1,
    DET_LOW = 2'h2,
    DET_HIGH = 2'h3
  } pomp_det_t;
endpackage

// *** pkg/pomp_unit_if.sv ***
// Signals between the register core and one timer unit's output logic
`timescale 1ns/1ps
interface pomp_unit_if;
  logic [7:0] mode;
  logic restart;
  logic stop_raw;
  logic stopped;
  logic run;
  logic [2:0] phase;
  logic [5:0] level;

  // Forced-stop detector
  modport stopper (
    input mode,
    input restart,
    input stop_raw,
    output stopped
  );
  // Output level driver
  modport driver (
    input mode,
    input stopped,
    input run,
    input phase,
    output level
  );
  // Register core
  modport core (
    output mode,
    output restart,
    output stop_raw,
    output run,
    output phase,
    input stopped,
    input level
  );
endinterface

// *** rtl/pomp_out_level.sv ***
// Output level generation for the three phase pairs of one unit
`timescale 1ns/1ps
module pomp_out_level (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Unit signals
  pomp_unit_if.driver bus
);
  logic [5:0] level;
  logic [5:0] next_level;
  logic alv;
  logic live;
  logic [2:0] pb;

  // Stopped or idle units park every first output at its inactive level
  always_comb begin
    alv = bus.mode[pomp_pkg::ACT_LVL_BIT];
    live = bus.run & ~bus.stopped;
    pb = {bus.mode[pomp_pkg::LAST_PB_BIT], bus.mode[pomp_pkg::MID_PB_BIT],
          bus.mode[pomp_pkg::FIRST_PB_BIT]};
    for (int p = 0; p < 3; p++) begin
      next_level[2*p] = (live & bus.phase[p]) ? alv : ~alv; // [RULE1]
      // Partner equals or inverts its first output
      next_level[2*p+1] = pb[p] ? next_level[2*p] : ~next_level[2*p]; // [RULE2] [RULE3]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level <= pomp_pkg::OUT_RST;
    end else begin
      level <= next_level;
    end
  end

  assign bus.level = level;

  active_level_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
    (bus.run && !bus.stopped && bus.phase[1])
      |=> level[2] == $past(bus.mode[pomp_pkg::ACT_LVL_BIT]))
    else $error("middle first output not at active level");

  mid_partner_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE2]
    1'b1 |=> level[3] ==
      ($past(bus.mode[pomp_pkg::MID_PB_BIT]) ? level[2] : ~level[2]))
    else $error("middle partner level wrong");

  last_partner_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE3]
    1'b1 |=> level[5] ==
      ($past(bus.mode[pomp_pkg::LAST_PB_BIT]) ? level[4] : ~level[4]))
    else $error("last partner level wrong");
endmodule

// *** rtl/pomp_stop_detect.sv ***
// Forced-stop input synchroniser, edge/level detector and stop latch
`timescale 1ns/1ps
module pomp_stop_detect (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Unit signals
  pomp_unit_if.stopper bus
);
  logic sync1;
  logic sync2;
  logic prev;
  logic hit;
  logic next_stopped;
  logic stopped;
  pomp_pkg::pomp_det_t sel;

  // Pin is asynchronous; sync1 feeds sync2 only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      prev <= 1'b0;
    end else begin
      sync1 <= bus.stop_raw;
      sync2 <= sync1;
      prev <= sync2;
    end
  end

  // Condition per select field, gated by the disable bit
  always_comb begin
    sel = pomp_pkg::pomp_det_t'({bus.mode[pomp_pkg::SEL_HI_BIT],
                       bus.mode[pomp_pkg::SEL_LO_BIT]});
    case (sel)
      pomp_pkg::DET_RISE: hit = sync2 & ~prev; // [RULE6]
      pomp_pkg::DET_FALL: hit = ~sync2 & prev; // [RULE6]
      pomp_pkg::DET_LOW: hit = ~sync2; // [RULE6]
      pomp_pkg::DET_HIGH: hit = sync2; // [RULE6]
      default: hit = 1'b0;
    endcase
    if (bus.mode[pomp_pkg::STOP_DIS_BIT]) begin
      hit = 1'b0; // [RULE5]
    end
  end

  // Detection beats restart; a held level keeps the stop alive
  always_comb begin
    next_stopped = stopped;
    if (hit) begin
      next_stopped = 1'b1;
    end else if (bus.restart) begin
      next_stopped = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stopped <= pomp_pkg::STOP_RST;
    end else begin
      stopped <= next_stopped;
    end
  end

  assign bus.stopped = stopped;

  sequence rise_seen_s;
    !prev && sync2;
  endsequence

  stop_gate_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE5]
    $rose(stopped) |-> !$past(bus.mode[pomp_pkg::STOP_DIS_BIT]))
    else $error("stop latched while forced stop disabled");

  rise_stop_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE6]
    (rise_seen_s and (bus.mode[3:0] == 4'h0)) |=> stopped)
    else $error("rising edge did not latch stop");

  level_stop_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE6]
    (bus.mode[3:0] == 4'h3 && sync2) |=> stopped)
    else $error("high level did not hold stop");
endmodule

// *** rtl/pomp_top.sv ***
// Output mode registers with protected write sequence, APB slave
// Function
// RULE1: Mode bit 7 sets active level of each pair's first output.
// RULE2: Bit 5: middle partner inverts (0) or matches (1) its first output.
// RULE3: Bit 4: last partner inverts (0) or matches (1) its first output.
// RULE4: Software keeps bit 5 fixed while the counter runs.
// RULE5: Bit 3 set ignores the forced-stop input; clear honours it.
// RULE6: Bits 1:0 pick rising, falling, low or high stop detection.
// RULE7: Software keeps the stop select fixed while the counter runs.
// RULE8: Software writes restart before changing the stop select.
// RULE9: A mode write not directly after an unlock write is dropped.
// RULE10: Unlock write then mode write stores; RMW bit ops work too.
// RULE11: Data written to the unlock register is discarded.
// RULE12: Software blocks interrupts between unlock and mode writes.
// RULE13: Only CPU accesses, never DMA, perform the sequence.
// RULE14: Mode reads need no unlock and keep the unlock state.
// RULE15: Any access to another address cancels a pending unlock.
`timescale 1ns/1ps
module pomp_top (
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB request
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  // APB answer
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Forced-stop pins, one per unit
  input wire logic [1:0] forced_stop_input,
  // Phase waveforms from the counters, three per unit
  input wire logic [5:0] phase_in,
  // Pin levels, six per unit
  output logic [11:0] pwm_out,
  // Unit state
  output logic [1:0] count_enable_bit,
  output logic [1:0] stop_status
);
  logic [7:0] timer_output_mode_reg [pomp_pkg::UNITS];
  logic [1:0] unlock_armed;
  logic [1:0] next_unlock;
  logic [1:0] cen;
  logic [1:0] restart;
  logic [1:0] stopped;
  logic [11:0] level_all;
  logic access_wait;
  logic done;
  logic unit;
  logic [3:0] off;
  logic in_map;
  logic hit_mode;
  logic hit_unlock;
  logic hit_ctrl;
  logic mapped;
  logic lane0;
  logic [31:0] next_rdata;

  // Address decode; each unit owns a 16-byte window
  always_comb begin
    unit = paddr[pomp_pkg::UNIT_SEL_BIT];
    off = paddr[3:0];
    in_map = (paddr[7:5] == pomp_pkg::MAP_HI_ZERO);
    hit_mode = in_map && (off == pomp_pkg::MODE_OFF);
    hit_unlock = in_map && (off == pomp_pkg::UNLOCK_OFF);
    hit_ctrl = in_map && (off == pomp_pkg::CTRL_OFF);
    mapped = hit_mode | hit_unlock | hit_ctrl;
    lane0 = pstrb[0];
  end

  // One wait cycle lets the answer come straight from flops
  assign access_wait = psel & penable & ~pready;
  assign done = psel & penable & pready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= access_wait;
    end
  end

  // Read data mux, zero for write-only and unmapped places
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (hit_mode) begin
      next_rdata[7:0] = timer_output_mode_reg[unit]; // [RULE14]
    end else if (hit_ctrl) begin
      next_rdata[pomp_pkg::STAT_BIT] = stopped[unit];
      next_rdata[pomp_pkg::CEN_BIT] = cen[unit];
    end
  end

  // Answer registered during the wait cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (access_wait) begin
      prdata <= pwrite ? 32'h0000_0000 : next_rdata;
      pslverr <= ~mapped;
    end else begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  // Unlock state: armed by the write itself, not its data
  always_comb begin
    next_unlock = unlock_armed;
    for (int u = 0; u < pomp_pkg::UNITS; u++) begin
      if (done) begin
        if (unit == 1'(u) && hit_unlock) begin
          if (pwrite) begin
            next_unlock[u] = 1'b1; // [RULE11]
          end else begin
            next_unlock[u] = 1'b0; // [RULE15]
          end
        end else if (unit == 1'(u) && hit_mode) begin
          // Reads leave the unlock alone so read-modify-write works
          if (pwrite) begin
            next_unlock[u] = 1'b0; // [RULE9]
          end
        end else begin
          next_unlock[u] = 1'b0; // [RULE15]
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlock_armed <= 2'h0;
    end else begin
      unlock_armed <= next_unlock;
    end
  end

  // Mode store; a bit op arrives as read then unlocked write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int u = 0; u < pomp_pkg::UNITS; u++) begin
        timer_output_mode_reg[u] <= pomp_pkg::MODE_RST;
      end
    end else begin
      for (int u = 0; u < pomp_pkg::UNITS; u++) begin
        if (done && pwrite && hit_mode && unit == 1'(u) && lane0 &&
            unlock_armed[u]) begin
          timer_output_mode_reg[u] <= pwdata[7:0] & pomp_pkg::MODE_WMASK; // [RULE10]
        end
      end
    end
  end

  // Control: count enable stored, restart is a write-one pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cen <= {pomp_pkg::CEN_RST, pomp_pkg::CEN_RST};
    end else begin
      for (int u = 0; u < pomp_pkg::UNITS; u++) begin
        if (done && pwrite && hit_ctrl && unit == 1'(u) && lane0) begin
          cen[u] <= pwdata[pomp_pkg::CEN_BIT];
        end
      end
    end
  end

  always_comb begin
    for (int u = 0; u < pomp_pkg::UNITS; u++) begin
      restart[u] = done && pwrite && hit_ctrl && unit == 1'(u) && lane0 &&
                   pwdata[pomp_pkg::RESTART_BIT];
    end
  end

  // One detector and one driver per unit
  for (genvar g = 0; g < pomp_pkg::UNITS; g++) begin : g_unit
    pomp_unit_if uif ();

    assign uif.mode = timer_output_mode_reg[g];
    assign uif.restart = restart[g];
    assign uif.stop_raw = forced_stop_input[g];
    assign uif.run = cen[g];
    assign uif.phase = phase_in[3*g +: 3];
    assign stopped[g] = uif.stopped;
    assign level_all[6*g +: 6] = uif.level;

    pomp_stop_detect u_stop (
      .pclk(pclk),
      .presetn(presetn),
      .bus(uif.stopper)
    );

    pomp_out_level u_out (
      .pclk(pclk),
      .presetn(presetn),
      .bus(uif.driver)
    );
  end

  // All driven from flops inside this module or the unit modules
  assign pwm_out = level_all;
  assign count_enable_bit = cen;
  assign stop_status = stopped;

  // Helpers for unit 0 checks
  logic w_mode0;
  logic w_unlock0;
  logic r_mode0;
  assign w_mode0 = done && pwrite && hit_mode && !unit && lane0;
  assign w_unlock0 = done && pwrite && hit_unlock && !unit;
  assign r_mode0 = done && !pwrite && hit_mode && !unit;

  // Unlock write, three quiet cycles, then the mode write completes
  sequence unlock_then_write_s;
    w_unlock0 ##1 (!done [*3]) ##1 w_mode0;
  endsequence

  locked_drop_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE9]
    (w_mode0 && !unlock_armed[0])
      |=> timer_output_mode_reg[0] == $past(timer_output_mode_reg[0]))
    else $error("locked mode write was stored");

  unlocked_store_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE10]
    unlock_then_write_s |=> timer_output_mode_reg[0] ==
      ($past(pwdata[7:0]) & pomp_pkg::MODE_WMASK))
    else $error("unlocked mode write not stored");

  dummy_data_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE11]
    w_unlock0 |=> unlock_armed[0] &&
      timer_output_mode_reg[0] == $past(timer_output_mode_reg[0]))
    else $error("unlock write did not arm or changed mode");

  read_keeps_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE14]
    r_mode0 |=> unlock_armed[0] == $past(unlock_armed[0]))
    else $error("mode read changed unlock state");

  read_data_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE14]
    (access_wait && !pwrite && hit_mode && !unit)
      |=> pready && prdata[7:0] == timer_output_mode_reg[0])
    else $error("mode read data wrong");

  other_cancel_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE15]
    (done && !(unit == 1'b0 && (hit_mode || hit_unlock)))
      |=> !unlock_armed[0])
    else $error("foreign access left unlock armed");

  answer_time_a: assert property (@(posedge pclk) disable iff (!presetn)
    access_wait |=> pready ##1 !pready)
    else $error("pready not one cycle after wait");
endmodule

// *** verif/testbench.sv ***
// Self-checking bench for the protected output mode registers
`timescale 1ns/1ps
module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] forced_stop_input = 2'h0;
  logic [5:0] phase_in = 6'h00;
  logic [11:0] pwm_out;
  logic [1:0] count_enable_bit;
  logic [1:0] stop_status;
  // Reference state of both units
  logic [7:0] mode_m [2];
  logic [1:0] unl_m = 2'h0;
  logic [1:0] cen_m = 2'h0;
  logic [1:0] stop_m = 2'h3;
  logic [7:0] b;
  logic [7:0] ia [7];
  integer seed = 32'h44e5cf5f;
  integer fail_count = 0;
  integer checks = 0;
  integer cycles = 0;

  pomp_top DUT (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .forced_stop_input(forced_stop_input), .phase_in(phase_in),
    .pwm_out(pwm_out), .count_enable_bit(count_enable_bit),
    .stop_status(stop_status)
  );

  // Free-running 250 MHz clock
  always #2 pclk = ~pclk;

  // Cut a hang short
  always @(posedge pclk) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      fail_count = fail_count + 1;
      finish_test;
    end
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task finish_test;
    if (fail_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // One APB transfer; model follows at the completing edge
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    logic u;
    logic bad;
    logic [31:0] exp;
    u = a[4];
    bad = a[7:5] != 3'h0;
    exp = 32'h0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    if (!bad && a[3:0] == 4'h0) exp = {24'h0, mode_m[u]};
    if (!bad && a[3:0] == 4'h8) exp = {29'h0, cen_m[u], 1'b0, stop_m[u]};
    if (!w) check(prdata, exp);
    check({31'h0, pslverr}, {31'h0, bad});
    psel <= 1'b0;
    penable <= 1'b0;
    // Unlock bookkeeping; a read of the own mode register keeps it
    if (bad) begin
      unl_m = 2'h0;
    end else if (w && a[3:0] == 4'h4) begin
      unl_m = 2'h0;
      unl_m[u] = 1'b1;
    end else if (w && a[3:0] == 4'h0) begin
      if (unl_m[u]) mode_m[u] = d[7:0] & pomp_pkg::MODE_WMASK;
      unl_m = 2'h0;
    end else if (!(a[3:0] == 4'h0 && unl_m[u])) begin
      unl_m = 2'h0;
    end
    if (!bad && w && a[3:0] == 4'h8) cen_m[u] = d[2];
  endtask

  // Protected store: unlock with dummy data, then the mode write
  task wmode(input logic [31:0] v);
    apb(b + 8'h4, 1'b1, $random(seed));
    apb(b, 1'b1, v);
  endtask

  // Pins, stop latches and enables against the model
  task chk_pwm;
    logic [11:0] e;
    logic f;
    for (int u = 0; u < 2; u++) begin
      for (int k = 0; k < 3; k++) begin
        f = (cen_m[u] && !stop_m[u] && phase_in[3*u+k]) ?
          mode_m[u][7] : !mode_m[u][7];
        e[6*u+2*k] = f;
        e[6*u+2*k+1] = mode_m[u][6-k] ? f : !f;
      end
    end
    check({20'h0, pwm_out}, {20'h0, e});
    check({30'h0, stop_status}, {30'h0, stop_m});
    check({30'h0, count_enable_bit}, {30'h0, cen_m});
  endtask

  // Main sequence
  initial begin
    mode_m[0] = 8'h00;
    mode_m[1] = 8'h00;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk_pwm;
    // Unlocked, locked and cancelled mode writes on both units
    for (int u = 0; u < 2; u++) begin
      b = {3'h0, u[0], 4'h0};
      apb(b, 1'b0, 32'h0);
      apb(b + 8'h8, 1'b0, 32'h0);
      apb(b, 1'b1, $random(seed));
      apb(b, 1'b0, 32'h0);
      ia = '{b, b ^ 8'h10, b + 8'h8, b + 8'h4, 8'h20, 8'he4, b ^ 8'h14};
      for (int j = 0; j < 7; j++) begin
        apb(b + 8'h4, 1'b1, $random(seed));
        apb(ia[j], j > 4, $random(seed));
        apb(b, 1'b1, $random(seed));
        apb(b, 1'b0, 32'h0);
      end
    end
    // Each detection mode: clear, run, then trip the pin
    for (int u = 0; u < 2; u++) begin
      b = {3'h0, u[0], 4'h0};
      for (int m = 0; m < 4; m++) begin
        apb(b + 8'h8, 1'b1, 32'h2);
        wmode(($random(seed) & 32'hf0) | m);
        forced_stop_input[u] <= (m == 1 || m == 2);
        phase_in <= $random(seed);
        repeat (6) @(posedge pclk);
        apb(b + 8'h8, 1'b1, 32'h6);
        stop_m[u] = 1'b0;
        repeat (3) @(posedge pclk);
        chk_pwm;
        forced_stop_input[u] <= !(m == 1 || m == 2);
        stop_m[u] = 1'b1;
        repeat (6) @(posedge pclk);
        chk_pwm;
      end
    end
    // Stop input disabled: pin noise ignored, outputs follow phases
    for (int n = 0; n < 6; n++) begin
      b = {3'h0, n[0], 4'h0};
      apb(b + 8'h8, 1'b1, 32'h2);
      wmode($random(seed) | 32'h08);
      apb(b + 8'h8, 1'b1, 32'h6);
      stop_m[n[0]] = 1'b0;
      for (int r = 0; r < 4; r++) begin
        forced_stop_input <= $random(seed);
        phase_in <= $random(seed);
        repeat (6) @(posedge pclk);
        chk_pwm;
      end
      forced_stop_input[n[0]] <= 1'b1;
    end
    finish_test;
  end
endmodule
